// *** test/fault_status_bank_tb_top.sv ***
// testbench for the fault status bank
`timescale 1ns/1ns
`default_nettype none
module fault_status_bank_tb_top;
  import fault_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic proto_err = 1'b0;
  logic supply_uv = 1'b0;
  logic supply_ov = 1'b0;
  logic thermal_sd = 1'b0;
  logic thermal_pw = 1'b0;
  logic [15:0] oc_detect = 16'h0000;
  logic [7:0] oc_upper_flags = 8'h00;
  logic [23:0] ol_flags = 24'h000000;
  logic cmd_valid, rsp_valid, all_outputs_off, load_fault_summary;
  logic [7:0] cmd_addr;
  status_byte_t rsp_data;
  logic [15:0] switch_off;
  int n_mismatch = 0;
  int checks = 0;
  logic [7:0] no_power_on_reset_flag_exp = 8'h00;
  always #25 clk_sys = ~clk_sys;
  fault_status_bank i_fault_status_bank (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .proto_err(proto_err), .supply_uv(supply_uv),
    .supply_ov(supply_ov), .thermal_sd(thermal_sd), .thermal_pw(thermal_pw),
    .oc_detect(oc_detect), .oc_upper_flags(oc_upper_flags), .ol_flags(ol_flags),
    .switch_off(switch_off), .all_outputs_off(all_outputs_off),
    .load_fault_summary(load_fault_summary));
  host_model i_host_model (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  // ====================
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic clr, input logic [4:0] sel, input logic [7:0] exp);
    status_byte_t d;
    logic ok;
    i_host_model.access(clr, sel, 1'b1, d, ok);
    chk("answer strobe", 16'h0001, {15'h0000, ok});
    chk("answer byte", {8'h00, exp}, {8'h00, d});
  endtask
  // one-cycle detector pulse: 0 prewarn, 1 shutdown, 2 over, 3 under, 4 protocol
  task automatic pulse(input int k);
    @(posedge clk_sys);
    {proto_err, supply_uv, supply_ov, thermal_sd, thermal_pw} <= 5'(1 << k);
    @(posedge clk_sys);
    {proto_err, supply_uv, supply_ov, thermal_sd, thermal_pw} <= 5'h00;
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_reset(input int n);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(1'b0, SEL_GLOBAL_E, 8'h00);
    rd(1'b0, SEL_OC_A_E, 8'h00);
    rd(1'b0, SEL_OC_B_E, 8'h00);
    no_power_on_reset_flag_exp = 8'h00;
  endtask
  task automatic t_global;
    logic [7:0] gbit [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h80};
    for (int k = 0; k < 5; k++) begin
      pulse(k);
      chk("outputs off", 16'((k >= 1) && (k <= 3)), all_outputs_off);
      rd(1'b1, SEL_GLOBAL_E, gbit[k] | no_power_on_reset_flag_exp);
      no_power_on_reset_flag_exp = 8'h08;
      rd(1'b0, SEL_GLOBAL_E, 8'h08);
      chk("outputs off", 16'h0000, all_outputs_off);
    end
  endtask
  task automatic t_oc;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      oc_detect <= 16'h0001 << i;
      @(posedge clk_sys);
      oc_detect <= 16'h0000;
      #1;
      chk("switch off", 16'h0001 << i, switch_off);
      rd(1'b0, SEL_GLOBAL_E, 8'h48);
      rd(1'b1, (i < 8) ? SEL_OC_A_E : SEL_OC_B_E, 8'h01 << (i % 8));
      rd(1'b0, (i < 8) ? SEL_OC_A_E : SEL_OC_B_E, 8'h00);
      chk("summary", 16'h0000, load_fault_summary);
    end
  endtask
  task automatic t_summary;
    @(posedge clk_sys);
    ol_flags <= 24'h800000;
    #1;
    chk("summary", 16'h0001, load_fault_summary);
    @(posedge clk_sys);
    ol_flags <= 24'h000000;
    oc_upper_flags <= 8'h80;
    #1;
    chk("summary", 16'h0001, load_fault_summary);
    rd(1'b0, SEL_GLOBAL_E, 8'h48);
    @(posedge clk_sys);
    oc_upper_flags <= 8'h00;
    #1;
    chk("summary", 16'h0000, load_fault_summary);
    rd(1'b0, SEL_GLOBAL_E, 8'h08);
  endtask
  task automatic t_persist;
    @(posedge clk_sys);
    supply_uv <= 1'b1;
    rd(1'b1, SEL_GLOBAL_E, 8'h28);
    rd(1'b1, SEL_GLOBAL_E, 8'h28);
    chk("outputs off", 16'h0001, all_outputs_off);
    @(posedge clk_sys);
    supply_uv <= 1'b0;
    rd(1'b1, SEL_GLOBAL_E, 8'h28);
    rd(1'b0, SEL_GLOBAL_E, 8'h08);
    chk("outputs off", 16'h0000, all_outputs_off);
  endtask
  task automatic t_frame;
    status_byte_t d;
    logic ok;
    i_host_model.access(1'b0, SEL_OC_A_E, 1'b0, d, ok);
    chk("answer strobe", 16'h0001, {15'h0000, ok});
    chk("answer byte", 16'h0000, {8'h00, d});
    rd(1'b1, 5'h1F, 8'h00);
    rd(1'b1, SEL_GLOBAL_E, 8'h88);
    rd(1'b0, SEL_GLOBAL_E, 8'h08);
  endtask
  initial begin
    t_reset(16);
    t_global;
    t_oc;
    t_summary;
    t_persist;
    t_frame;
    pulse(4);
    t_reset(2);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
endmodule
`default_nettype wire

// *** test/host_model.sv ***
// host side model issuing status frames
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input wire logic clk_sys,
  // command out, answer back
  output logic cmd_valid,
  output logic [7:0] cmd_addr,
  input wire logic rsp_valid,
  input wire fault_pkg::status_byte_t rsp_data
);
  import fault_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_addr = 8'h00;
  end
  // ====================
  // one frame: address byte out, data byte back
  task automatic access(input logic clr, input logic [4:0] sel, input logic tl,
    output status_byte_t d, output logic ok);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_addr <= {clr, sel, 1'b0, tl};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_addr <= ~{clr, sel, 1'b0, tl};
    #1;
    ok = rsp_valid;
    d = rsp_data;
  endtask
endmodule
`default_nettype wire

// *** verilog/fault_consts.svh ***
// constants for the global and overcurrent fault status register bank
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH
`define SEL_GLOBAL 5'h06
`define SEL_OC_A 5'h16
`define SEL_OC_B 5'h0E
`define ADDR_CLR_BIT 7
`define ADDR_SEL_HI 6
`define ADDR_SEL_LO 2
`define ADDR_TAIL_BIT 1
`define ADDR_ONE_BIT 0
`define BIT_PROTO 7
`define BIT_LOAD 6
`define BIT_UV 5
`define BIT_OV 4
`define BIT_NO_POWER_ON_RESET_FLAG 3
`define BIT_TSD 2
`define BIT_PW 1
`define BIT_RSVD 0
`define GLOBAL_RC_MASK 8'hB6
`define OC_CLR_MASK 8'hFF
`define FLAGS_RESET 8'h00
`define NO_POWER_ON_RESET_FLAG_RESET 1'b0
`endif

// *** verilog/fault_pkg.sv ***
// types shared by the fault status bank
`default_nettype none
`include "fault_consts.svh"
package fault_pkg;
  typedef logic [7:0] status_byte_t;
  typedef enum logic [4:0] {
    SEL_GLOBAL_E = `SEL_GLOBAL,
    SEL_OC_A_E = `SEL_OC_A,
    SEL_OC_B_E = `SEL_OC_B
  } reg_sel_t;
endpackage
`default_nettype wire

// *** verilog/fault_status_bank.sv ***
// global and overcurrent status registers behind the serial command port
`timescale 1ns/1ns
`default_nettype none
`include "fault_consts.svh"
module fault_status_bank (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // decoded command: address byte of a 16-bit frame
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_addr,
  // response byte for the data half of the frame
  output logic rsp_valid,
  output fault_pkg::status_byte_t rsp_data,
  // fault detectors, high while the condition is present
  input wire logic proto_err,
  input wire logic supply_uv,
  input wire logic supply_ov,
  input wire logic thermal_sd,
  input wire logic thermal_pw,
  input wire logic [15:0] oc_detect,
  // flags latched outside this bank, feeding the summary
  input wire logic [7:0] oc_upper_flags,
  input wire logic [23:0] ol_flags,
  // power stage controls and status
  output logic [15:0] switch_off,
  output logic all_outputs_off,
  output logic load_fault_summary
);
  import fault_pkg::*;

  // ==========================================
  // command decode
  function automatic logic is_sel(input logic [7:0] addr, input reg_sel_t sel);
    is_sel = addr[`ADDR_SEL_HI:`ADDR_SEL_LO] == sel;
  endfunction

  logic clr_cmd;
  logic hit_global;
  logic hit_oc_a;
  logic hit_oc_b;
  logic bad_frame;
  assign clr_cmd = cmd_valid && cmd_addr[`ADDR_CLR_BIT];
  assign hit_global = is_sel(cmd_addr, SEL_GLOBAL_E);
  assign hit_oc_a = is_sel(cmd_addr, SEL_OC_A_E);
  assign hit_oc_b = is_sel(cmd_addr, SEL_OC_B_E);
  // address byte must end in one
  assign bad_frame = cmd_valid && !cmd_addr[`ADDR_ONE_BIT];

  // ==========================================
  // latched flags
  status_byte_t glob_set;
  status_byte_t glob_clr;
  status_byte_t glob_flags;
  status_byte_t oc_a;
  status_byte_t oc_b;
  status_byte_t oc_a_clr;
  status_byte_t oc_b_clr;

  always_comb begin
    glob_set = `FLAGS_RESET;
    glob_set[`BIT_PROTO] = proto_err || bad_frame;
    glob_set[`BIT_UV] = supply_uv;
    glob_set[`BIT_OV] = supply_ov;
    glob_set[`BIT_TSD] = thermal_sd;
    glob_set[`BIT_PW] = thermal_pw;
    glob_clr = (clr_cmd && hit_global) ? `GLOBAL_RC_MASK : `FLAGS_RESET;
    oc_a_clr = (clr_cmd && hit_oc_a) ? `OC_CLR_MASK : `FLAGS_RESET;
    oc_b_clr = (clr_cmd && hit_oc_b) ? `OC_CLR_MASK : `FLAGS_RESET;
  end

  // detectors held high re-set their flag even in the clearing cycle
  flag_latch u_global (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set_bits(glob_set),
    .clr_bits(glob_clr),
    .flags(glob_flags)
  );

  flag_latch u_oc_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set_bits(oc_detect[7:0]),
    .clr_bits(oc_a_clr),
    .flags(oc_a)
  );

  flag_latch u_oc_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .set_bits(oc_detect[15:8]),
    .clr_bits(oc_b_clr),
    .flags(oc_b)
  );

  // ==========================================
  // reset indicator: cleared to one by the host
  logic no_power_on_reset_flag_r;
  logic no_power_on_reset_flag_nxt;

  always_comb begin
    no_power_on_reset_flag_nxt = no_power_on_reset_flag_r;
    if (clr_cmd && hit_global) begin
      no_power_on_reset_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      no_power_on_reset_flag_r <= `NO_POWER_ON_RESET_FLAG_RESET;
    end else begin
      no_power_on_reset_flag_r <= no_power_on_reset_flag_nxt;
    end
  end

  // ==========================================
  // summary and power stage
  assign load_fault_summary = (|oc_a) || (|oc_b) || (|oc_upper_flags)
    || (|ol_flags);
  assign switch_off = {oc_b, oc_a};
  assign all_outputs_off = glob_flags[`BIT_UV] || glob_flags[`BIT_OV]
    || glob_flags[`BIT_TSD];

  status_byte_t glob_view;
  always_comb begin
    glob_view = glob_flags;
    glob_view[`BIT_LOAD] = load_fault_summary;
    glob_view[`BIT_NO_POWER_ON_RESET_FLAG] = no_power_on_reset_flag_r;
    glob_view[`BIT_RSVD] = 1'b0;
  end

  // ==========================================
  // response: value before any clear of this frame
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  status_byte_t rsp_data_r;
  status_byte_t rsp_data_nxt;

  always_comb begin
    rsp_valid_nxt = cmd_valid;
    rsp_data_nxt = rsp_data_r;
    if (cmd_valid) begin
      if (hit_global) begin
        rsp_data_nxt = glob_view;
      end else if (hit_oc_a) begin
        rsp_data_nxt = oc_a;
      end else if (hit_oc_b) begin
        rsp_data_nxt = oc_b;
      end else begin
        rsp_data_nxt = `FLAGS_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= `FLAGS_RESET;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;

  // ==========================================
  // checks
  property p_proto_flag;
    @(posedge clk_sys) disable iff (sys_rst)
    proto_err |=> glob_flags[`BIT_PROTO];
  endproperty
  a_proto_flag: assert property (p_proto_flag)
    else $error("protocol error not latched");

  // any switch overcurrent must show in the summary one edge later
  property p_summary;
    @(posedge clk_sys) disable iff (sys_rst)
    (|oc_detect) |=> load_fault_summary;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary misses overcurrent");

  property p_summary_drop;
    @(posedge clk_sys) disable iff (sys_rst)
    (clr_cmd && hit_oc_a && oc_b == 8'h00 && oc_detect == 16'h0000
      && oc_upper_flags == 8'h00 && ol_flags == 24'h000000) |=> !load_fault_summary;
  endproperty
  a_summary_drop: assert property (p_summary_drop)
    else $error("summary stuck after clear");

  property p_uv_off;
    @(posedge clk_sys) disable iff (sys_rst)
    supply_uv |=> glob_flags[`BIT_UV] && all_outputs_off;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("undervoltage not handled");

  property p_ov_off;
    @(posedge clk_sys) disable iff (sys_rst)
    supply_ov |=> glob_flags[`BIT_OV] && all_outputs_off;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("overvoltage not handled");

  property p_no_power_on_reset_flag_rise;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(no_power_on_reset_flag_r) |-> $past(clr_cmd && hit_global);
  endproperty
  a_no_power_on_reset_flag_rise: assert property (p_no_power_on_reset_flag_rise)
    else $error("reset flag rose without clear");

  property p_tsd_off;
    @(posedge clk_sys) disable iff (sys_rst)
    thermal_sd |=> glob_flags[`BIT_TSD] && all_outputs_off;
  endproperty
  a_tsd_off: assert property (p_tsd_off)
    else $error("shutdown not handled");

  property p_pw_only;
    @(posedge clk_sys) disable iff (sys_rst)
    (thermal_pw && !all_outputs_off && !supply_uv && !supply_ov && !thermal_sd)
      |=> glob_flags[`BIT_PW] && !all_outputs_off;
  endproperty
  a_pw_only: assert property (p_pw_only)
    else $error("prewarning misbehaves");

  property p_rsvd_zero;
    @(posedge clk_sys) disable iff (sys_rst)
    (cmd_valid && hit_global) |=> rsp_valid && !rsp_data[`BIT_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bit set");

  property p_read_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (clr_cmd && hit_oc_a && oc_detect[7:0] == 8'h00) |=> oc_a == 8'h00
      && rsp_data == $past(oc_a);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read and clear failed");

  property p_switch_off;
    @(posedge clk_sys) disable iff (sys_rst)
    oc_detect[15] |=> switch_off[15] && oc_b[7];
  endproperty
  a_switch_off: assert property (p_switch_off)
    else $error("switch not disabled");
endmodule
`default_nettype wire

// *** verilog/flag_latch.sv ***
// sticky flag byte: set wins over clear
`timescale 1ns/1ns
`default_nettype none
`include "fault_consts.svh"
module flag_latch (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // set and clear strobes, one per bit
  input wire fault_pkg::status_byte_t set_bits,
  input wire fault_pkg::status_byte_t clr_bits,
  // latched flags
  output fault_pkg::status_byte_t flags
);
  import fault_pkg::*;
  status_byte_t flags_r;
  status_byte_t flags_nxt;

  always_comb begin
    flags_nxt = (flags_r & ~clr_bits) | set_bits;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= `FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule
`default_nettype wire
